// ### hw/kcp_pkg.sv
package kcp_pkg;
  // Bus framing
  localparam logic [6:0] SLV_ADDR = 7'h51;
  localparam int unsigned DIR_BIT = 0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] TX_DONE = 4'h8;
  localparam logic [3:0] TX_WAIT = 4'h9;
  // Command codes
  localparam logic [7:0] CMD_READ_INT = 8'hD0;
  localparam logic [7:0] CMD_PIN_EN = 8'hD1;
  localparam logic [7:0] CMD_READ_STAT = 8'hE0;
  localparam logic [7:0] CMD_ACTIVE = 8'hE4;
  localparam logic [7:0] CMD_READ_ERR = 8'hF0;
  // Status codes
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] STAT_ACK = 8'h06;
  localparam logic [7:0] STAT_NACK = 8'h15;
  // Interrupt cause bit positions
  localparam int unsigned INT_KEY = 0;
  localparam int unsigned INT_PA = 1;
  localparam int unsigned INT_PB = 2;
  localparam int unsigned INT_ERR = 3;
  // Fault cause bit positions
  localparam int unsigned ERR_EARLY = 0;
  localparam int unsigned ERR_UNK = 1;
  localparam int unsigned ERR_KEYS = 2;
  localparam int unsigned ERR_LOST = 4;
  localparam int unsigned ERR_OVF = 6;
  // Timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned ACT_STEP_US = 3000;
  localparam int unsigned STEP_CYC = ACT_STEP_US * CLK_MHZ;
  localparam int unsigned ACT_DEF_MS = 500;
  localparam logic [7:0] ACT_DEF_N = 8'(ACT_DEF_MS * 1000 / ACT_STEP_US);
  localparam int unsigned STRETCH_NS = 40;
  localparam logic [3:0] STRETCH_CYC = 4'((STRETCH_NS * CLK_MHZ + 999) / 1000);
  // Reset values
  localparam logic [1:0] PIN_EN_RST = 2'h0;
  // Command port states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_SKIP = 3'b101
  } kcp_state_t;
endpackage

// ### hw/kcp_link_if.sv
// Byte capture results passed from the serial clock domain to the core
interface kcp_link_if;
  logic [7:0] data;
  logic byte_tgl;
  logic ack_bit;
  logic ack_tgl;
  logic frame_clr;
  modport link (output data, output byte_tgl, output ack_bit, output ack_tgl, input frame_clr);
  modport core (input data, input byte_tgl, input ack_bit, input ack_tgl, output frame_clr);
endinterface

// ### hw/kcp_sync.sv
module kcp_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } kcp_sync_t;
  kcp_sync_t s_ff;
  kcp_sync_t nxt_s;

  // First stage feeds only the second stage
  always_comb begin
    nxt_s.s1 = d;
    nxt_s.s2 = s_ff.s1;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.s2;
endmodule

// ### hw/kcp_link.sv
module kcp_link (
  // Serial clock domain
  input wire logic scl_clk,
  input wire logic reset,
  // Serial data as seen on the wire
  input wire logic sda_i,
  // Results to the core
  kcp_link_if.link lk
);
  import kcp_pkg::*;

  typedef struct packed {
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] data;
    logic bt;
    logic ab;
    logic at;
  } kcp_lk_t;
  kcp_lk_t s_ff;
  kcp_lk_t nxt_s;
  wire logic clr;

  // Core holds this domain cleared between frames, so no edge outside a frame matters
  assign clr = reset | lk.frame_clr;

  //////////////////////////////////////////////////////////////////////////////
  // Shift in eight bits, then sample the acknowledge bit
  always_comb begin
    nxt_s = s_ff;
    if (s_ff.cnt == ACK_SLOT) begin
      // Ninth bit: acknowledge from whichever side received
      nxt_s.cnt = 4'h0;
      nxt_s.ab = sda_i;
      nxt_s.at = ~s_ff.at;
    end else begin
      nxt_s.sh = {s_ff.sh[6:0], sda_i};
      nxt_s.cnt = s_ff.cnt + 4'h1;
      if (s_ff.cnt == BIT_LAST) begin
        // Byte stands stable for the next eight clocks
        nxt_s.data = {s_ff.sh[6:0], sda_i};
        nxt_s.bt = ~s_ff.bt;
      end
    end
  end

  always_ff @(posedge scl_clk or posedge clr) begin
    if (clr) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lk.data = s_ff.data;
  assign lk.byte_tgl = s_ff.bt;
  assign lk.ack_bit = s_ff.ab;
  assign lk.ack_tgl = s_ff.at;
endmodule

// ### hw/kcp_port.sv
module kcp_port #(
  parameter int unsigned STEP_CYC = kcp_pkg::STEP_CYC
) (
  // Core clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Serial clock pin, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Serial data pin, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Interrupt request to host
  output logic irq_n,
  // Event sources from keypad logic
  input wire logic key_event,
  input wire logic fifo_full,
  input wire logic keys_over,
  input wire logic req_withdrawn,
  // Interrupt-capable pins
  input wire logic event_pin_a,
  input wire logic event_pin_b,
  // Settings and state seen by the rest of the chip
  output logic [1:0] pin_event_en,
  output logic [7:0] halt_delay_setting,
  output logic core_halted
);
  import kcp_pkg::*;

  typedef struct packed {
    kcp_state_t st;
    logic scl_p;
    logic sda_p;
    logic pa_p;
    logic pb_p;
    logic bt_p;
    logic at_p;
    logic frame_clr;
    logic ack_pend;
    logic ack_on;
    logic [7:0] cmd;
    logic [7:0] tx;
    logic [3:0] tx_cnt;
    logic [3:0] strc;
    logic scl_oe;
    logic sda_oe;
    logic drv_lvl;
    logic [3:0] icode;
    logic [7:0] ecode;
    logic [7:0] stat;
    logic irq_n;
    logic [1:0] pin_en;
    logic [7:0] act_n;
    logic [19:0] step;
    logic [7:0] left;
    logic halted;
    logic wake_nack;
  } kcp_core_t;

  kcp_core_t s_ff; // Registered state
  kcp_core_t nxt_s; // Next state
  kcp_link_if lk(); // Serial domain results
  logic [5:0] sy; // Synchronised pins and toggles
  logic scl_s, sda_s, pa_s, pb_s, bt_s, at_s;

  //////////////////////////////////////////////////////////////////////////////
  // Serial clock domain: bit capture runs on the pin clock itself
  kcp_link u_link (
    .scl_clk(scl_i),
    .reset(reset),
    .sda_i(sda_i),
    .lk(lk.link)
  );

  // Pins and serial domain toggles pass two flops before use
  kcp_sync #(.W(6)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .d({lk.ack_tgl, lk.byte_tgl, event_pin_b, event_pin_a, sda_i, scl_i}),
    .q(sy)
  );
  assign {at_s, bt_s, pb_s, pa_s, sda_s, scl_s} = sy;
  assign lk.frame_clr = s_ff.frame_clr;

  //////////////////////////////////////////////////////////////////////////////
  // Core state update
  always_comb begin
    logic start_ev, stop_ev, fall_ev, byte_ev, ack_ev;
    logic pa_ev, pb_ev, int_rd, err_rd, act_ev;
    logic [3:0] iset;
    logic [7:0] eset;
    logic [7:0] b;
    nxt_s = s_ff;
    b = lk.data;
    int_rd = 1'b0;
    err_rd = 1'b0;
    eset = 8'h00;
    iset = 4'h0;
    start_ev = 1'b0;
    stop_ev = 1'b0;
    fall_ev = 1'b0;
    byte_ev = 1'b0;
    ack_ev = 1'b0;
    pa_ev = 1'b0;
    pb_ev = 1'b0;
    act_ev = 1'b0;
    nxt_s.scl_p = scl_s;
    nxt_s.sda_p = sda_s;
    nxt_s.pa_p = pa_s;
    nxt_s.pb_p = pb_s;
    // Bus conditions; host only changes data with clock low except to frame
    start_ev = scl_s & s_ff.scl_p & s_ff.sda_p & ~sda_s;
    stop_ev = scl_s & s_ff.scl_p & ~s_ff.sda_p & sda_s;
    fall_ev = s_ff.scl_p & ~scl_s;
    // A cleared serial domain may reset its toggles, so track them silently
    byte_ev = ~s_ff.frame_clr & (bt_s != s_ff.bt_p);
    ack_ev = ~s_ff.frame_clr & (at_s != s_ff.at_p);
    nxt_s.bt_p = bt_s;
    nxt_s.at_p = at_s;

    // Frame boundaries: clear serial domain, release data line
    if (start_ev) begin
      nxt_s.frame_clr = 1'b1;
      nxt_s.st = ST_ADDR;
      nxt_s.ack_pend = 1'b0;
      nxt_s.ack_on = 1'b0;
      nxt_s.sda_oe = 1'b0;
      if (s_ff.halted) begin
        nxt_s.wake_nack = 1'b1;
      end
    end else if (stop_ev) begin
      nxt_s.frame_clr = 1'b1;
      nxt_s.st = ST_IDLE;
      nxt_s.ack_pend = 1'b0;
      nxt_s.ack_on = 1'b0;
      nxt_s.sda_oe = 1'b0;
    end else if (s_ff.frame_clr && !scl_s && s_ff.st != ST_IDLE) begin
      // Clock low after Start: bit capture may run
      nxt_s.frame_clr = 1'b0;
    end

    // Received byte handling
    if (byte_ev) begin
      case (s_ff.st)
        ST_ADDR: begin
          // Any first address after wake clears the pending refusal
          nxt_s.wake_nack = 1'b0;
          if (b[7:1] != SLV_ADDR) begin
            nxt_s.st = ST_SKIP;
          end else if (s_ff.wake_nack) begin
            // Not ready yet: leave address unacknowledged
            nxt_s.st = ST_SKIP;
            eset[ERR_EARLY] = 1'b1;
          end else if (b[DIR_BIT]) begin
            // Read: answer for the last command seen
            nxt_s.ack_pend = 1'b1;
            nxt_s.st = ST_RDATA;
            nxt_s.tx_cnt = 4'h0;
            if (s_ff.cmd == CMD_READ_INT) begin
              nxt_s.tx = {4'h0, s_ff.icode};
              int_rd = 1'b1;
            end else if (s_ff.cmd == CMD_READ_ERR) begin
              nxt_s.tx = s_ff.ecode;
              err_rd = 1'b1;
            end else if (s_ff.cmd == CMD_READ_STAT) begin
              nxt_s.tx = s_ff.stat;
            end else begin
              nxt_s.tx = 8'h00;
            end
          end else begin
            nxt_s.ack_pend = 1'b1;
            nxt_s.st = ST_CMD;
          end
        end
        ST_CMD: begin
          // Command code follows the write address
          nxt_s.cmd = b;
          nxt_s.ack_pend = 1'b1;
          nxt_s.st = ST_WDATA;
          if (b == CMD_READ_INT || b == CMD_READ_ERR) begin
            nxt_s.stat = STAT_ACK;
          end else if (b != CMD_READ_STAT && b != CMD_PIN_EN && b != CMD_ACTIVE) begin
            // Status read keeps reporting the command before it
            eset[ERR_UNK] = 1'b1;
            nxt_s.stat = STAT_NACK;
          end
        end
        ST_WDATA: begin
          // Data bytes of a write command
          nxt_s.ack_pend = 1'b1;
          if (s_ff.cmd == CMD_PIN_EN) begin
            nxt_s.pin_en = b[1:0];
            nxt_s.stat = STAT_ACK;
          end else if (s_ff.cmd == CMD_ACTIVE) begin
            if (b != 8'h00) begin
              nxt_s.act_n = b;
              nxt_s.stat = STAT_ACK;
            end else begin
              // Zero is outside the valid range; setting kept
              nxt_s.stat = STAT_NACK;
            end
          end
        end
        default: begin
          // Idle, refused or read phase: byte ignored
          nxt_s.st = s_ff.st;
        end
      endcase
    end

    // Host answer to a sent byte
    if (ack_ev && s_ff.st == ST_RDATA && s_ff.tx_cnt == TX_WAIT) begin
      if (lk.ack_bit) begin
        nxt_s.st = ST_SKIP;
      end else begin
        // Further bytes of a read carry zero
        nxt_s.tx = 8'h00;
        nxt_s.tx_cnt = 4'h0;
      end
    end

    // Data line changes only after a clock fall
    if (fall_ev && !start_ev && !stop_ev) begin
      if (s_ff.ack_pend) begin
        nxt_s.ack_pend = 1'b0;
        nxt_s.ack_on = 1'b1;
        nxt_s.sda_oe = 1'b1;
        if (s_ff.st == ST_RDATA) begin
          // Hold the clock low while the answer is settled
          nxt_s.scl_oe = 1'b1;
          nxt_s.strc = STRETCH_CYC;
        end
      end else if (s_ff.st == ST_RDATA && s_ff.tx_cnt < TX_DONE) begin
        nxt_s.ack_on = 1'b0;
        nxt_s.sda_oe = ~s_ff.tx[7];
        nxt_s.tx = {s_ff.tx[6:0], 1'b0};
        nxt_s.tx_cnt = s_ff.tx_cnt + 4'h1;
      end else begin
        // End of acknowledge or last bit: release for the receiver
        nxt_s.ack_on = 1'b0;
        nxt_s.sda_oe = 1'b0;
        if (s_ff.st == ST_RDATA && s_ff.tx_cnt == TX_DONE) begin
          nxt_s.tx_cnt = TX_WAIT;
        end
      end
    end

    // Clock stretch countdown
    if (s_ff.scl_oe) begin
      if (s_ff.strc <= 4'h1) begin
        nxt_s.scl_oe = 1'b0;
      end else begin
        nxt_s.strc = s_ff.strc - 4'h1;
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Event sources
    pa_ev = s_ff.pin_en[0] & (pa_s != s_ff.pa_p);
    pb_ev = s_ff.pin_en[1] & (pb_s != s_ff.pb_p);
    if (s_ff.pin_en == 2'b11) begin
      iset[INT_PA] = pa_ev;
      iset[INT_PB] = pb_ev;
    end else begin
      iset[INT_PA] = pa_ev | pb_ev;
      iset[INT_PB] = pa_ev | pb_ev;
    end
    iset[INT_KEY] = key_event;
    eset[ERR_OVF] = key_event & fifo_full;
    eset[ERR_LOST] = req_withdrawn;
    eset[ERR_KEYS] = keys_over;
    iset[INT_ERR] = |eset;

    // Set wins over a clear in the same cycle
    nxt_s.icode = (int_rd ? 4'h0 : s_ff.icode) | iset;
    nxt_s.ecode = (err_rd ? 8'h00 : s_ff.ecode) | eset;
    if (|iset) begin
      nxt_s.irq_n = 1'b0;
    end else if (int_rd) begin
      nxt_s.irq_n = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////////
    // Active time: n steps of about 3 ms without activity enters halt
    // Stop reloads too, so a new setting counts from the end of its own write
    act_ev = (|iset) | start_ev | stop_ev;
    if (act_ev) begin
      nxt_s.halted = 1'b0;
      nxt_s.step = 20'h0_0000;
      nxt_s.left = s_ff.act_n;
    end else if (!s_ff.halted) begin
      if (s_ff.step == 20'(STEP_CYC - 1)) begin
        nxt_s.step = 20'h0_0000;
        if (s_ff.left <= 8'h01) begin
          nxt_s.halted = 1'b1;
        end else begin
          nxt_s.left = s_ff.left - 8'h01;
        end
      end else begin
        nxt_s.step = s_ff.step + 20'h0_0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.frame_clr <= 1'b1;
      s_ff.stat <= STAT_RESET;
      s_ff.irq_n <= 1'b1;
      s_ff.pin_en <= PIN_EN_RST;
      s_ff.act_n <= ACT_DEF_N;
      s_ff.left <= ACT_DEF_N;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign scl_o = s_ff.drv_lvl;
  assign scl_oe = s_ff.scl_oe;
  assign sda_o = s_ff.drv_lvl;
  assign sda_oe = s_ff.sda_oe;
  assign irq_n = s_ff.irq_n;
  assign pin_event_en = s_ff.pin_en;
  assign halt_delay_setting = s_ff.act_n;
  assign core_halted = s_ff.halted;
endmodule

// ### bench/kcp_port_asserts.sv
// Watches the command port from its pins only
module kcp_port_asserts #(
  parameter int unsigned STEP_CYC = 10
) (
  // Core clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Serial pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Interrupt and event sources
  input wire logic irq_n,
  input wire logic key_event,
  input wire logic fifo_full,
  input wire logic keys_over,
  input wire logic req_withdrawn,
  input wire logic event_pin_a,
  input wire logic event_pin_b,
  // Settings
  input wire logic [1:0] pin_event_en,
  input wire logic [7:0] halt_delay_setting,
  input wire logic core_halted
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  // Open drain: only the enables may ever pull a line
  a_open_drain_low: assert property (!scl_o && !sda_o)
    else $error("drive value not zero");
  // Any error or key source pulls the request low next cycle
  a_irq_on_event: assert property ((key_event || keys_over || req_withdrawn) |=> !irq_n)
    else $error("irq not raised");
  // Release comes only from a received read address byte
  a_irq_release_scl: assert property ($rose(irq_n) |-> scl_i)
    else $error("irq released outside a bus bit");
  // Stretch stands exactly eight core cycles
  a_stretch_len: assert property ($rose(scl_oe) |-> scl_oe[*8] ##1 !scl_oe)
    else $error("stretch length wrong");
  // SDA may move only while SCL is low, else it forms Start or Stop
  a_sda_on_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda changed with scl high");
  // Zero is outside the legal active time and is ignored
  a_delay_nonzero: assert property ($changed(halt_delay_setting) |-> halt_delay_setting != 8'h00)
    else $error("active time zero taken");
  // Settings land while the last data bit is on the wire
  a_pin_en_scl: assert property ($changed(pin_event_en) |-> scl_i)
    else $error("pin enable changed off a bit");
  // A Start wakes a halted core within a few cycles
  a_wake_on_start: assert property ((core_halted && scl_i && $fell(sda_i)) |-> ##[1:8] !core_halted)
    else $error("start did not wake");
endmodule

bind kcp_port kcp_port_asserts #(.STEP_CYC(STEP_CYC)) u_chk (.mclk(mclk), .reset(reset), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq_n(irq_n),
  .key_event(key_event), .fifo_full(fifo_full), .keys_over(keys_over), .req_withdrawn(req_withdrawn),
  .event_pin_a(event_pin_a), .event_pin_b(event_pin_b), .pin_event_en(pin_event_en),
  .halt_delay_setting(halt_delay_setting), .core_halted(core_halted));

// ### bench/kcp_host_model.sv
// Bus master model; outputs at 1 release the line to its pull-up
module kcp_host_model (
  // Wire levels
  input wire logic scl_w,
  input wire logic sda_w,
  // Drive, low pulls the wire
  output logic scl_h,
  output logic sda_h
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus idle high; clock stands still between frames
  initial begin
    scl_h = 1'b1;
    sda_h = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // Start or repeated start; SCL high well past the minimum
  task automatic start();
    sda_h = 1'b1;
    #31;
    scl_h = 1'b1;
    #120;
    sda_h = 1'b0;
    #120;
    scl_h = 1'b0;
    #31;
  endtask
  // Stop ends the frame
  task automatic stop();
    sda_h = 1'b0;
    #31;
    scl_h = 1'b1;
    #120;
    sda_h = 1'b1;
    #120;
  endtask
  // One bit; high phase waits while the device holds SCL low
  task automatic clk_bit(input logic b, output logic s);
    int n;
    sda_h = b;
    #31;
    scl_h = 1'b1;
    n = 0;
    while (scl_w !== 1'b1 && n < 40) begin
      #5;
      n++;
    end
    #31;
    s = sda_w;
    #31.5;
    scl_h = 1'b0;
    #31.5;
  endtask
  // Byte out MSB first, ack sampled in the ninth bit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  // Byte in; last=1 answers with a NACK to end the data
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, s);
  endtask
endmodule

// ### bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Inputs and outputs of the block
  logic mclk, reset, key_event, fifo_full, keys_over, req_withdrawn, event_pin_a, event_pin_b;
  logic scl_o, scl_oe, sda_o, sda_oe, irq_n, core_halted, host_scl, host_sda, a;
  logic [1:0] pin_event_en;
  logic [7:0] halt_delay_setting;
  wire logic scl_w;
  wire logic sda_w;
  int err_total, cmp_count, cyc;
  // Open-drain wires with pull-ups
  assign scl_w = host_scl & ~scl_oe;
  assign sda_w = host_sda & ~sda_oe;
  // Short step keeps halt tests inside the run
  kcp_port #(.STEP_CYC(1000)) dut (.mclk(mclk), .reset(reset), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq_n(irq_n), .key_event(key_event),
    .fifo_full(fifo_full), .keys_over(keys_over), .req_withdrawn(req_withdrawn), .event_pin_a(event_pin_a),
    .event_pin_b(event_pin_b), .pin_event_en(pin_event_en), .halt_delay_setting(halt_delay_setting),
    .core_halted(core_halted));
  kcp_host_model host (.scl_w(scl_w), .sda_w(sda_w), .scl_h(host_scl), .sda_h(host_sda));
  ////////////////////////////////////////////////////////////
  // 200 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // Command with one data byte
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic k;
    host.start();
    host.wbyte(8'hA2, k);
    chk({7'h0, k}, 8'h01);
    host.wbyte(c, k);
    chk({7'h0, k}, 8'h01);
    host.wbyte(d, k);
    chk({7'h0, k}, 8'h01);
    host.stop();
  endtask
  // Read command through a repeated start
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
    logic k;
    logic [7:0] v;
    host.start();
    host.wbyte(8'hA2, k);
    chk({7'h0, k}, 8'h01);
    host.wbyte(c, k);
    chk({7'h0, k}, 8'h01);
    host.start();
    host.wbyte(8'hA3, k);
    chk({7'h0, k}, 8'h01);
    host.rbyte(1'b1, v);
    host.stop();
    chk(v, exp);
  endtask
  // Bounded wait for the core to halt
  task automatic wait_halt();
    int n;
    n = 0;
    while (core_halted !== 1'b1 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    chk({7'h0, core_halted}, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {key_event, fifo_full, keys_over, req_withdrawn, event_pin_a, event_pin_b} = '0;
    reset = 1'b1;
    repeat (12) @(posedge mclk);
    @(negedge mclk) reset = 1'b0;
    repeat (4) @(negedge mclk);
    chk({7'h0, irq_n}, 8'h01);
    chk(halt_delay_setting, 8'hA6);
    rd_chk(8'hE0, 8'h00);
    done("reset");
    // Two event cycles; flags must all pile up
    @(negedge mclk);
    key_event = 1'b1;
    fifo_full = 1'b1;
    @(negedge mclk);
    {key_event, fifo_full, keys_over, req_withdrawn} = 4'h3;
    @(negedge mclk);
    {keys_over, req_withdrawn} = 2'h0;
    @(negedge mclk);
    chk({7'h0, irq_n}, 8'h00);
    rd_chk(8'hD0, 8'h09);
    chk({7'h0, irq_n}, 8'h01);
    rd_chk(8'hD0, 8'h00);
    rd_chk(8'hF0, 8'h54);
    rd_chk(8'hF0, 8'h00);
    rd_chk(8'hE0, 8'h06);
    done("events");
    // Unknown command is taken but flagged
    rd_chk(8'h5A, 8'h00);
    rd_chk(8'hE0, 8'h15);
    rd_chk(8'hF0, 8'h02);
    rd_chk(8'hD0, 8'h08);
    done("unknown");
    // Single pin sets both bits; two pins each their own
    wr(8'hD1, 8'h01);
    chk({6'h0, pin_event_en}, 8'h01);
    @(negedge mclk) event_pin_a = 1'b1;
    repeat (8) @(negedge mclk);
    rd_chk(8'hD0, 8'h06);
    wr(8'hD1, 8'h03);
    @(negedge mclk) event_pin_b = 1'b1;
    repeat (8) @(negedge mclk);
    rd_chk(8'hD0, 8'h04);
    @(negedge mclk) event_pin_a = 1'b0;
    repeat (8) @(negedge mclk);
    rd_chk(8'hD0, 8'h02);
    done("pins");
    // Active time: zero refused, then halt and two Start wakes, own address then foreign address
    wr(8'hE4, 8'h00);
    chk(halt_delay_setting, 8'hA6);
    rd_chk(8'hE0, 8'h15);
    wr(8'hE4, 8'h01);
    chk(halt_delay_setting, 8'h01);
    wait_halt();
    host.start();
    host.wbyte(8'hA2, a);
    chk({7'h0, a}, 8'h00);
    host.stop();
    wr(8'hE4, 8'h01);
    wait_halt();
    host.start();
    host.wbyte(8'h01, a);
    chk({7'h0, a}, 8'h00);
    wr(8'hE4, 8'hA6);
    chk(halt_delay_setting, 8'hA6);
    rd_chk(8'hF0, 8'h01);
    done("halt");
    // Foreign address is left alone
    host.start();
    host.wbyte(8'hA4, a);
    chk({7'h0, a}, 8'h00);
    host.stop();
    done("address");
    summarize();
  end
endmodule
